/* File: include/ext_bus_ctrl_pkg.sv */
// Behaviour
// - single-chip mode suppresses all external bus activity
// - driven address width selectable zero to 24, larger settings clamped to 24
// - data path eight or sixteen bits wide
// - multiplexed or demultiplexed bus per configuration
// - demux drives low address on separate lines
// - segment line count limits space, frees unused lines
// - active-low chip select per window plus default
// - per-window timing and function configuration sets
// - ready input with configurable active level
// - four windows each with own range setting
// - window 4 over 3, 2 over 1
// - no window hit uses default settings
// - only selected window asserts its chip select
// - bus timing follows reference clock rising edge
// - bus mode switches per access by window
// - internal peripheral bus served like external parts
// - reserved regions still produce external bus cycles
package ext_bus_ctrl_pkg;

   // ---------------------------------------------
   // widths and fixed positions
   // ---------------------------------------------
   localparam int ADDR_W = 24;      // full address width
   localparam int DATA_W = 16;      // widest data path
   localparam int NUM_WIN = 4;      // address windows
   localparam int CS_W = 5;         // windows plus default
   localparam int RANGE_W = 12;     // window base bits 23:12
   localparam int SEG_LSB = 16;     // first segment line
   localparam logic [7:0] IPB_SEG_DEF = 8'h20;   // peripheral segment
   localparam logic [4:0] CS_IDLE = 5'h1f;       // no select
   localparam logic [15:0] OE_OFF = 16'hffff;    // data lines released
   localparam logic [23:0] AOE_OFF = 24'hffffff; // address released

   // ---------------------------------------------
   // configuration carriers
   // ---------------------------------------------
   typedef struct packed
   {
      logic [1:0] addr_ext;   // extra address phases
      logic [3:0] rw_wait;    // fixed wait phases
      logic [1:0] hold;       // phases after strobe
   } timing_cfg_t;

   typedef struct packed
   {
      logic win_en;    // window active
      logic mux;       // 1 multiplexed, 0 demultiplexed
      logic wide;      // 1 sixteen bits, 0 eight bits
      logic rdy_en;    // ready input honoured
      logic rdy_pol;   // active level of ready
   } function_cfg_t;

   typedef struct packed
   {
      logic [RANGE_W-1:0] base;   // address bits 23:12
      logic [3:0] size;           // 4K shifted by size
   } range_cfg_t;

   typedef struct packed
   {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic write;
   } req_t;

   typedef struct packed
   {
      req_t req;
      logic [2:0] win;        // 0 default, 1..4 window
      logic internal;         // peripheral bus target
      logic [4:0] aw;         // driven address width
      logic [2:0] seg;        // segment lines in use
      timing_cfg_t tim;
      function_cfg_t fcn;
   } job_t;

   // ---------------------------------------------
   // state records
   // ---------------------------------------------
   typedef enum logic [2:0] {B_IDLE, B_ADDR, B_DATA, B_HOLD, B_DONE} bus_state_t;

   typedef struct packed
   {
      job_t job;              // held while busy
      logic req_tgl;          // request event
      logic ack_s1;
      logic ack_s2;
      logic ack_s3;
      logic ack_seen;
      logic busy;
      logic rdy;              // request port free
      logic done;             // answer pulse
      logic [DATA_W-1:0] rdata;
   } sys_st_t;

   typedef struct packed
   {
      bus_state_t state;
      job_t job;
      logic [3:0] cnt;
      logic refclk;
      logic req_s1;
      logic req_s2;
      logic req_s3;
      logic req_seen;
      logic ack_tgl;
      logic rdy_s1;
      logic rdy_s2;
      logic rdy_s3;
      logic [DATA_W-1:0] rdata;
      logic [DATA_W-1:0] ad_out;
      logic [DATA_W-1:0] ad_oe_n;
      logic [ADDR_W-1:0] addr_out;
      logic [ADDR_W-1:0] addr_oe_n;
      logic ale;
      logic rd_n;
      logic wr_n;
      logic [CS_W-1:0] cs_n;
      logic ipb_sel;
      logic ipb_write;
      logic [ADDR_W-1:0] ipb_addr;
      logic [DATA_W-1:0] ipb_wdata;
   } bus_st_t;

endpackage

/* File: hdl/ext_bus_ctrl.sv */
`timescale 1ns/10ps
module ext_bus_ctrl
#(
   parameter logic [7:0] IPB_SEG = ext_bus_ctrl_pkg::IPB_SEG_DEF
)
(
   // clocks and reset
   input wire logic sys_clk,
   input wire logic bus_clk,
   input wire logic nrst,
   // global configuration
   input wire logic single_chip,
   input wire logic [4:0] addr_width,
   input wire logic [2:0] seg_lines,
   // default and window configuration
   input ext_bus_ctrl_pkg::timing_cfg_t default_timing_cfg,
   input ext_bus_ctrl_pkg::function_cfg_t default_function_cfg,
   input ext_bus_ctrl_pkg::timing_cfg_t [3:0] window_timing_cfg,
   input ext_bus_ctrl_pkg::function_cfg_t [3:0] window_function_cfg,
   input ext_bus_ctrl_pkg::range_cfg_t [3:0] window_range_select,
   // on-chip request port
   input wire logic req_valid,
   input ext_bus_ctrl_pkg::req_t req,
   output logic req_ready,
   output logic resp_valid,
   output logic [15:0] resp_rdata,
   // external bus pins
   output logic bus_ref_clock_out,
   output logic ale_out,
   output logic rd_n_out,
   output logic wr_n_out,
   output logic [4:0] cs_n_out,
   output logic [23:0] addr_out,
   output logic [23:0] addr_oe_n,
   input wire logic [15:0] ad_in,
   output logic [15:0] ad_out,
   output logic [15:0] ad_oe_n,
   input wire logic ready_in,
   // internal peripheral bus
   output logic ipb_sel,
   output logic ipb_write,
   output logic [23:0] ipb_addr,
   output logic [15:0] ipb_wdata,
   input wire logic [15:0] ipb_rdata,
   input wire logic ipb_ready
);
   import ext_bus_ctrl_pkg::*;

   sys_st_t sys_reg;      // system side state
   sys_st_t sys_next;
   bus_st_t bus_reg;      // link side state
   bus_st_t bus_next;
   logic [3:0] hit;       // window hits
   logic [2:0] win_sel;   // chosen window
   job_t new_job;         // job built from request
   logic [23:0] line_en;  // address lines in use
   logic step;            // reference clock rises
   logic rdy_ok;          // device allows completion

   // ---------------------------------------------
   // window decode
   // ---------------------------------------------
   // per-window range compare on bits 23:12
   generate
      for (genvar w = 0; w < NUM_WIN; w++)
      begin : g_win
         logic [RANGE_W-1:0] msk;
         assign msk = ~(12'(12'h001 << window_range_select[w].size) - 12'h001);
         // enabled window, address inside range
         assign hit[w] = window_function_cfg[w].win_en &&
            (((req.addr[23:12] ^ window_range_select[w].base) & msk) == 12'h000);
      end
   endgenerate

   // higher window number wins on overlap
   always_comb
   begin
      if (hit[3])
         win_sel = 3'h4;
      else if (hit[2])
         win_sel = 3'h3;
      else if (hit[1])
         win_sel = 3'h2;
      else if (hit[0])
         win_sel = 3'h1;
      else
         win_sel = 3'h0;
   end

   // job record, settled before the cycle starts
   always_comb
   begin
      new_job.req = req;
      new_job.win = win_sel;
      // peripheral segment goes to the internal bus
      new_job.internal = (req.addr[23:16] == IPB_SEG);
      new_job.aw = (addr_width > 5'h18) ? 5'h18 : addr_width;
      new_job.seg = seg_lines;
      // default set unless a window was hit
      if (win_sel == 3'h0)
      begin
         new_job.tim = default_timing_cfg;
         new_job.fcn = default_function_cfg;
      end
      else
      begin
         new_job.tim = window_timing_cfg[2'(win_sel - 3'h1)];
         new_job.fcn = window_function_cfg[2'(win_sel - 3'h1)];
      end
   end

   // ---------------------------------------------
   // system side: accept, hand over, answer
   // ---------------------------------------------
   always_comb
   begin
      sys_next = sys_reg;
      sys_next.done = 1'b0;
      // acknowledge event from the link side
      sys_next.ack_s1 = bus_reg.ack_tgl;
      sys_next.ack_s2 = sys_reg.ack_s1;
      sys_next.ack_s3 = sys_reg.ack_s2;
      if (sys_reg.busy && (sys_reg.ack_s2 == sys_reg.ack_s3) &&
          (sys_reg.ack_s3 != sys_reg.ack_seen))
      begin
         // read data held stable by link side
         sys_next.ack_seen = sys_reg.ack_s3;
         sys_next.busy = 1'b0;
         sys_next.done = 1'b1;
         sys_next.rdata = bus_reg.rdata;
      end
      else if (sys_reg.rdy && req_valid)
      begin
         // take the request
         if (single_chip && !new_job.internal)
         begin
            // no external activity, answer at once
            sys_next.done = 1'b1;
            sys_next.rdata = 16'h0000;
         end
         else
         begin
            // reserved areas are not filtered out
            sys_next.job = new_job;
            sys_next.busy = 1'b1;
            sys_next.req_tgl = ~sys_reg.req_tgl;
         end
      end
      sys_next.rdy = !sys_next.busy;
   end

   // system side register
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         sys_reg <= '0;
      else
         sys_reg <= sys_next;
   end

   // ---------------------------------------------
   // address line enables
   // ---------------------------------------------
   // low lines need width and demux; upper need width and segment count
   generate
      for (genvar i = 0; i < ADDR_W; i++)
      begin : g_line
         if (i < SEG_LSB)
         begin : g_lo
            assign line_en[i] = (5'(i) < sys_reg.job.aw) && !sys_reg.job.fcn.mux;
         end
         else
         begin : g_hi
            assign line_en[i] = (5'(i) < sys_reg.job.aw) &&
               (3'(i - SEG_LSB) < sys_reg.job.seg);
         end
      end
   endgenerate

   // phases advance only as the reference clock rises
   assign step = !bus_reg.refclk;

   // completion gate: peripheral answer or agreed ready level
   always_comb
   begin
      if (bus_reg.job.internal)
         rdy_ok = ipb_ready;
      else
         rdy_ok = !bus_reg.job.fcn.rdy_en ||
            ((bus_reg.rdy_s2 == bus_reg.rdy_s3) &&
             (bus_reg.rdy_s3 == bus_reg.job.fcn.rdy_pol));
   end

   // ---------------------------------------------
   // link side bus sequencer
   // ---------------------------------------------
   always_comb
   begin
      bus_next = bus_reg;
      bus_next.refclk = ~bus_reg.refclk;
      // request event and ready pin synchronisers
      bus_next.req_s1 = sys_reg.req_tgl;
      bus_next.req_s2 = bus_reg.req_s1;
      bus_next.req_s3 = bus_reg.req_s2;
      bus_next.rdy_s1 = ready_in;
      bus_next.rdy_s2 = bus_reg.rdy_s1;
      bus_next.rdy_s3 = bus_reg.rdy_s2;
      unique case (bus_reg.state)
         B_IDLE:
         begin
            // new job once the toggle has settled
            if (step && (bus_reg.req_s2 == bus_reg.req_s3) &&
                (bus_reg.req_s3 != bus_reg.req_seen))
            begin
               bus_next.req_seen = bus_reg.req_s3;
               bus_next.job = sys_reg.job;
               if (sys_reg.job.internal)
               begin
                  // peripheral bus carries the access, no external bus cycle
                  bus_next.ipb_sel = 1'b1;
                  bus_next.ipb_write = sys_reg.job.req.write;
                  bus_next.ipb_addr = sys_reg.job.req.addr;
                  bus_next.ipb_wdata = sys_reg.job.req.wdata;
                  bus_next.cnt = 4'h0;
                  bus_next.state = B_DATA;
               end
               else
               begin
                  // only the chosen window selects
                  bus_next.cs_n = CS_IDLE & ~(5'h01 << sys_reg.job.win);
                  bus_next.addr_out = sys_reg.job.req.addr & line_en;
                  bus_next.addr_oe_n = ~line_en;
                  bus_next.ale = 1'b1;
                  if (sys_reg.job.fcn.mux)
                  begin
                     // address phase on shared lines
                     bus_next.ad_out = sys_reg.job.req.addr[15:0];
                     bus_next.ad_oe_n = sys_reg.job.fcn.wide ? 16'h0000 : 16'hff00;
                  end
                  else
                     bus_next.ad_oe_n = OE_OFF;
                  bus_next.cnt = {2'b00, sys_reg.job.tim.addr_ext};
                  bus_next.state = B_ADDR;
               end
            end
         end
         B_ADDR:
         begin
            if (step)
            begin
               if (bus_reg.cnt != 4'h0)
               begin
                  // stretched address phase
                  bus_next.cnt = bus_reg.cnt - 4'h1;
               end
               else
               begin
                  // strobe phase, width picks driven lanes
                  bus_next.ale = 1'b0;
                  bus_next.rd_n = bus_reg.job.req.write;
                  bus_next.wr_n = !bus_reg.job.req.write;
                  bus_next.ad_out = bus_reg.job.req.wdata;
                  bus_next.ad_oe_n = !bus_reg.job.req.write ? OE_OFF :
                     (bus_reg.job.fcn.wide ? 16'h0000 : 16'hff00);
                  bus_next.cnt = bus_reg.job.tim.rw_wait;
                  bus_next.state = B_DATA;
               end
            end
         end
         B_DATA:
         begin
            if (step)
            begin
               if (bus_reg.cnt != 4'h0)
               begin
                  // programmed wait phases
                  bus_next.cnt = bus_reg.cnt - 4'h1;
               end
               else if (!rdy_ok)
                  bus_next.cnt = 4'h0; // ready inactive, phase held
               else if (bus_reg.job.internal)
               begin
                  // peripheral answer taken
                  bus_next.rdata = ipb_rdata;
                  bus_next.ipb_sel = 1'b0;
                  bus_next.ipb_write = 1'b0;
                  bus_next.state = B_HOLD;
               end
               else
               begin
                  // capture read data, end strobe
                  bus_next.rdata = bus_reg.job.fcn.wide ? ad_in :
                     {8'h00, ad_in[7:0]};
                  bus_next.rd_n = 1'b1;
                  bus_next.wr_n = 1'b1;
                  bus_next.cnt = {2'b00, bus_reg.job.tim.hold};
                  bus_next.state = B_HOLD;
               end
            end
         end
         B_HOLD:
         begin
            if (step)
            begin
               if (bus_reg.cnt != 4'h0)
               begin
                  // data and select held after strobe
                  bus_next.cnt = bus_reg.cnt - 4'h1;
               end
               else
               begin
                  // release data lines, drop select; address lines stay driven
                  bus_next.cs_n = CS_IDLE;
                  bus_next.ad_oe_n = OE_OFF;
                  bus_next.state = B_DONE;
               end
            end
         end
         B_DONE:
         begin
            // answer event back to system side
            bus_next.ack_tgl = ~bus_reg.ack_tgl;
            bus_next.state = B_IDLE;
         end
      endcase
   end

   // link side register
   always_ff @(posedge bus_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         bus_reg <= '0;
         bus_reg.state <= B_IDLE;
         bus_reg.ad_oe_n <= OE_OFF;
         bus_reg.addr_oe_n <= AOE_OFF;
         bus_reg.rd_n <= 1'b1;
         bus_reg.wr_n <= 1'b1;
         bus_reg.cs_n <= CS_IDLE;
      end
      else
      begin
         bus_reg <= bus_next;
      end
   end

   // ---------------------------------------------
   // outputs, all from flip-flops
   // ---------------------------------------------
   assign req_ready = sys_reg.rdy;
   assign resp_valid = sys_reg.done;
   assign resp_rdata = sys_reg.rdata;
   assign bus_ref_clock_out = bus_reg.refclk;
   assign ale_out = bus_reg.ale;
   assign rd_n_out = bus_reg.rd_n;
   assign wr_n_out = bus_reg.wr_n;
   assign cs_n_out = bus_reg.cs_n;
   assign addr_out = bus_reg.addr_out;
   assign addr_oe_n = bus_reg.addr_oe_n;
   assign ad_out = bus_reg.ad_out;
   assign ad_oe_n = bus_reg.ad_oe_n;
   assign ipb_sel = bus_reg.ipb_sel;
   assign ipb_write = bus_reg.ipb_write;
   assign ipb_addr = bus_reg.ipb_addr;
   assign ipb_wdata = bus_reg.ipb_wdata;

endmodule

/* File: tb/ext_bus_ctrl_assertions.sv */
`timescale 1ns/10ps
module ext_bus_ctrl_assertions
(
   // clocks and reset
   input wire logic sys_clk,
   input wire logic bus_clk,
   input wire logic nrst,
   // request side
   input wire logic single_chip,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire logic resp_valid,
   // bus pins
   input wire logic bus_ref_clock_out,
   input wire logic ale_out,
   input wire logic rd_n_out,
   input wire logic wr_n_out,
   input wire logic [4:0] cs_n_out,
   input wire logic [15:0] ad_oe_n,
   // peripheral bus
   input wire logic ipb_sel,
   input wire logic ipb_ready,
   input wire logic [23:0] ipb_addr
);
   import ext_bus_ctrl_pkg::*;
   // ----------------------------------------
   // link side properties
   // ----------------------------------------
   property p_cs_one;
      @(posedge bus_clk) disable iff (!nrst) $onehot0(~cs_n_out);
   endproperty
   a_cs_one: assert property (p_cs_one) else $error("two selects low");
   property p_sc_quiet;
      @(posedge bus_clk) disable iff (!nrst)
         single_chip |-> rd_n_out && wr_n_out && cs_n_out == CS_IDLE;
   endproperty
   a_sc_quiet: assert property (p_sc_quiet) else $error("bus active in single chip");
   property p_ref_phase;
      @(posedge bus_clk) disable iff (!nrst)
         $changed({ale_out, rd_n_out, wr_n_out, cs_n_out}) |-> $rose(bus_ref_clock_out);
   endproperty
   a_ref_phase: assert property (p_ref_phase) else $error("pin moved off ref rise");
   property p_strobe_cs;
      @(posedge bus_clk) disable iff (!nrst) !(rd_n_out && wr_n_out) |-> cs_n_out != CS_IDLE;
   endproperty
   a_strobe_cs: assert property (p_strobe_cs) else $error("strobe without select");
   property p_read_release;
      @(posedge bus_clk) disable iff (!nrst) !rd_n_out |-> ad_oe_n == OE_OFF;
   endproperty
   a_read_release: assert property (p_read_release) else $error("data driven in read");
   property p_write_drive;
      @(posedge bus_clk) disable iff (!nrst) !wr_n_out |-> ad_oe_n != OE_OFF;
   endproperty
   a_write_drive: assert property (p_write_drive) else $error("write not driven");
   property p_cs_hold;
      @(posedge bus_clk) disable iff (!nrst)
         cs_n_out != CS_IDLE && $past(cs_n_out) != CS_IDLE |-> $stable(cs_n_out);
   endproperty
   a_cs_hold: assert property (p_cs_hold) else $error("select changed in access");
   property p_ale_start;
      @(posedge bus_clk) disable iff (!nrst)
         $rose(ale_out) |-> cs_n_out != CS_IDLE && rd_n_out && wr_n_out;
   endproperty
   a_ale_start: assert property (p_ale_start) else $error("bad address phase");
   property p_ipb_hold;
      @(posedge bus_clk) disable iff (!nrst)
         ipb_sel && !ipb_ready |=> ipb_sel && $stable(ipb_addr);
   endproperty
   a_ipb_hold: assert property (p_ipb_hold) else $error("peripheral cycle dropped");
   // ----------------------------------------
   // request side properties
   // ----------------------------------------
   property p_busy;
      // busy after take, or answered at once in single-chip mode
      @(posedge sys_clk) disable iff (!nrst) req_valid && req_ready |=> !req_ready || resp_valid;
   endproperty
   a_busy: assert property (p_busy) else $error("second request taken");
   // main scenarios seen
   c_read: cover property (@(posedge bus_clk) disable iff (!nrst) !rd_n_out);
   c_write: cover property (@(posedge bus_clk) disable iff (!nrst) !wr_n_out);
   c_ipb: cover property (@(posedge bus_clk) disable iff (!nrst) ipb_sel && ipb_ready);
endmodule
bind ext_bus_ctrl ext_bus_ctrl_assertions u_chk (.sys_clk, .bus_clk, .nrst, .single_chip,
   .req_valid, .req_ready, .resp_valid, .bus_ref_clock_out, .ale_out, .rd_n_out, .wr_n_out,
   .cs_n_out, .ad_oe_n, .ipb_sel, .ipb_ready, .ipb_addr);

/* File: tb/ext_mem_model.sv */
`timescale 1ns/10ps
module ext_mem_model
(
   // link side
   input wire logic bus_clk,
   input wire logic nrst,
   input wire logic ale_out,
   input wire logic rd_n_out,
   input wire logic wr_n_out,
   input wire logic [23:0] addr_out,
   input wire logic [23:0] addr_oe_n,
   input wire logic [15:0] ad_out,
   output logic [15:0] ad_in,
   output logic ready_in,
   // bench control and view
   input wire logic rdy_pol,
   input wire logic [3:0] slow,
   output logic [23:0] lat_addr,
   output logic [15:0] wr_data
);
   logic [4:0] cnt; // cycles into strobe
   logic strobe; // read or write strobe low
   assign strobe = !rd_n_out || !wr_n_out;
   // ----------------------------------------
   // latch, reply data, ready
   // ----------------------------------------
   always @(posedge bus_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cnt <= 5'h00;
         ad_in <= 16'h0000;
         ready_in <= 1'b0;
         lat_addr <= 24'h000000;
         wr_data <= 16'h0000;
      end
      else
      begin
         // low lines released means multiplexed
         if (ale_out)
            lat_addr <= addr_oe_n[0] ? {addr_out[23:16] & ~addr_oe_n[23:16], ad_out}
               : addr_out & ~addr_oe_n;
         cnt <= strobe ? cnt + 5'(cnt != 5'h1f) : 5'h00;
         // active level only once slow count is reached
         ready_in <= (strobe && cnt >= 5'(slow)) ? rdy_pol : !rdy_pol;
         // released data lines keep changing
         ad_in <= !rd_n_out ? lat_addr[15:0] ^ 16'h5a5a : ~ad_in;
         if (!wr_n_out)
            wr_data <= ad_out;
      end
   end
endmodule

/* File: tb/ext_bus_ctrl_bench.sv */
`timescale 1ns/10ps
module ext_bus_ctrl_bench;
   import ext_bus_ctrl_pkg::*;
   // ----------------------------------------
   // stimulus and wires
   // ----------------------------------------
   logic sys_clk = 1'b0;
   logic bus_clk = 1'b0;
   logic nrst = 1'b0;
   logic single_chip = 1'b0;
   logic [4:0] aw = 5'h18;
   logic [2:0] seg = 3'h7;
   timing_cfg_t dt = 8'h00;
   function_cfg_t df = 5'h14; // on, demux, wide
   timing_cfg_t [3:0] wt = {8'h41, 8'h0c, 8'h00, 8'h00}; // window 3 waits, 4 stretched
   function_cfg_t [3:0] wf = {5'h18, 5'h10, 5'h1c, 5'h16};
   range_cfg_t [3:0] wrng = {16'h3000, 16'h3004, 16'h1000, 16'h1004};
   logic req_valid = 1'b0;
   req_t req = '0;
   logic [3:0] slow = 4'h0;
   logic [15:0] ipb_rdata = 16'h0000;
   logic ipb_ready = 1'b0;
   logic req_ready, resp_valid, refclk, ale, rd_n, wr_n, ready_in, ipb_sel, ipb_write;
   logic [4:0] cs_n;
   logic [23:0] addr_o, aoe_n, ipb_addr, lat_addr, aoe_seen;
   logic [15:0] resp_rdata, ad_in, ad_o, ad_oe_n, ipb_wdata, wr_data, d, msk;
   logic [4:0] cs_seen;
   logic ipb_w_seen;
   int err_count = 0;
   int n_checks = 0;
   int strobe_n, sel_n;
   int sc[6], sl[6];
   logic [23:0] tab_a[6] = '{24'h100010, 24'h101000, 24'h300000, 24'h305000,
      24'h500000, 24'h00f300};
   int tab_k[6] = '{2, 1, 4, 3, 0, 0}; // last one reserved area
   // ----------------------------------------
   // clocks, design, far side
   // ----------------------------------------
   always #10 sys_clk = ~sys_clk;
   always #40 bus_clk = ~bus_clk;
   ext_bus_ctrl u_dut (.sys_clk, .bus_clk, .nrst, .single_chip, .addr_width(aw),
      .seg_lines(seg), .default_timing_cfg(dt), .default_function_cfg(df),
      .window_timing_cfg(wt), .window_function_cfg(wf), .window_range_select(wrng),
      .req_valid, .req, .req_ready, .resp_valid, .resp_rdata, .bus_ref_clock_out(refclk),
      .ale_out(ale), .rd_n_out(rd_n), .wr_n_out(wr_n), .cs_n_out(cs_n), .addr_out(addr_o),
      .addr_oe_n(aoe_n), .ad_in, .ad_out(ad_o), .ad_oe_n, .ready_in, .ipb_sel, .ipb_write,
      .ipb_addr, .ipb_wdata, .ipb_rdata, .ipb_ready);
   ext_mem_model u_mem (.bus_clk, .nrst, .ale_out(ale), .rd_n_out(rd_n), .wr_n_out(wr_n),
      .addr_out(addr_o), .addr_oe_n(aoe_n), .ad_out(ad_o), .ad_in, .ready_in,
      .rdy_pol(wf[0].rdy_pol), .slow, .lat_addr, .wr_data);
   // peripheral responder and pin watcher
   always @(posedge bus_clk)
   begin
      ipb_ready <= ipb_sel;
      ipb_rdata <= ipb_sel ? ipb_addr[15:0] + 16'h0001 : ~ipb_rdata;
      if (ale)
      begin
         cs_seen <= cs_n;
         aoe_seen <= aoe_n;
      end
      if (!rd_n || !wr_n)
         strobe_n++;
      if (cs_n != CS_IDLE)
         sel_n++;
      if (ipb_sel)
         ipb_w_seen <= ipb_write;
   end
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task chk(input logic [23:0] seen, input logic [23:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task tally_and_finish;
      if (err_count == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // one request, held until taken, then wait for answer
   task access(input logic [23:0] a, input logic [15:0] w, input logic wr);
      int t;
      t = 0;
      strobe_n = 0;
      sel_n = 0;
      @(posedge sys_clk);
      req_valid <= 1'b1;
      req <= '{a, w, wr};
      do @(posedge sys_clk); while (req_ready !== 1'b1);
      req_valid <= 1'b0;
      do
      begin
         @(posedge sys_clk);
         t++;
      end
      while (resp_valid !== 1'b1 && t < 4000);
      if (t >= 4000)
         chk(24'h0, 24'h1);
      d = resp_rdata;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_windows;
      for (int i = 0; i < 6; i++)
      begin
         msk = (tab_k[i] > 2) ? 16'h00ff : 16'hffff;
         access(tab_a[i], ~tab_a[i][15:0], 1'b1);
         chk(lat_addr, tab_a[i]);
         chk(24'(wr_data & msk), 24'(~tab_a[i][15:0] & msk));
         chk(24'(cs_seen), 24'(CS_IDLE & ~(5'h01 << tab_k[i])));
         access(tab_a[i], 16'h0000, 1'b0);
         chk(24'(d), 24'((tab_a[i][15:0] ^ 16'h5a5a) & msk));
         sc[i] = strobe_n;
         sl[i] = sel_n;
      end
      chk(24'(sc[3] >= sc[4] + 6), 24'h1);
      chk(24'(sl[2] - sl[4]), 24'h4);
      chk(24'(sc[5] != 0), 24'h1);
   endtask
   task t_ready;
      int s0;
      for (int p = 0; p < 2; p++)
      begin
         wf[0] <= {4'hb, p[0]};
         slow <= 4'h0;
         access(24'h101000, 16'h0000, 1'b0);
         s0 = strobe_n;
         slow <= 4'hc;
         access(24'h101000, 16'h0000, 1'b0);
         chk(24'(strobe_n > s0 + 8), 24'h1);
         chk(24'(d), 24'h1000 ^ 24'h5a5a);
      end
   endtask
   task t_width;
      aw <= 5'h08;
      access(24'h500000, 16'h0000, 1'b0);
      chk(24'(aoe_seen[15:0]), 24'hff00);
      aw <= 5'h18;
      seg <= 3'h3;
      access(24'h500000, 16'h0000, 1'b0);
      chk(24'(aoe_seen[23:16]), 24'hf8);
      seg <= 3'h7;
   endtask
   task t_single;
      single_chip <= 1'b1;
      access(24'h500000, 16'h0000, 1'b0);
      chk(24'(d), 24'h0);
      chk(24'(strobe_n), 24'h0);
      for (int s = 1; s >= 0; s--)
      begin
         single_chip <= s[0];
         access(24'h201234, 16'h0000, 1'b0);
         chk(24'(d), 24'h1235);
         chk(24'(strobe_n), 24'h0);
      end
      // peripheral write carries direction, data and address
      access(24'h200040, 16'hbeef, 1'b1);
      chk(24'({ipb_w_seen, ipb_wdata}), 24'h1beef);
      chk(ipb_addr, 24'h200040);
   endtask
   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial
   begin
      repeat (16) @(posedge sys_clk);
      nrst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      t_windows();
      t_ready();
      t_width();
      t_single();
      tally_and_finish();
   end
   initial
   begin
      #1000000;
      err_count++;
      tally_and_finish();
   end
endmodule
